//--- rtc_core.sv
/*
  Receive support logic: collision position capture, decoder blanking
  timer, no-response timer, signal strength capture and registers.
  Assumes host register port and frame events on CLK_SYS, decoder bit
  events on LNK_CLK, and level codes straight from analog pins.
*/
// How it works
// RULE1 - A bit collision sets the collision flag and raises the request.
// RULE2 - Type A collision position goes to 0x0E plus bits 7:6 of 0x0D.
// RULE3 - Position counts bits from zero, starting just after the start bit.
// RULE4 - After transmit ends decoders stay reset for blanking value times 9.44 us.
// RULE5 - Writing protocol select reloads the blanking time preset.
// RULE6 - No tag response within timeout times 37.76 us sets flag and request.
// RULE7 - Every protocol selection presets the no-response timeout.
// RULE8 - Internal strength blocks latch the peak level seen.
// RULE9 - Each reader transmission clears stored strength values. Here a strength store in the same cycle wins over the clear.
// RULE10 - Main and auxiliary 3-bit codes share the strength register 0x0F.
// RULE11 - Control bit 1 picks internal or external result for the register.
// RULE12 - Command 0x18 measures internal, 0x19 external, into strength register.
// RULE13 - Host turns transmitter on for internal, off for external measurement.
// RULE14 - Host waits 50 us after a command before reading strength register.
// RULE15 - Reading the strength register clears it.
// RULE16 - Host writes protocol select first, then fine-tunes other registers.
// RULE17 - Every protocol select write reloads all related presets.
// RULE18 - End of receive drives the request output high.
// RULE19 - Every request cause, receive errors included, reads from 0x0C.
// RULE20 - Host joins 0x0D bits 7:6 above 0x0E into the position.
// RULE21 - Both timers tick from the core clock by fixed division.
`timescale 1ns/1ns
module rtc_core #(
  parameter int POS_W = 10
) (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  input wire logic LNK_CLK,
  input wire logic LNK_SOF,
  input wire logic LNK_BIT,
  input wire logic LNK_COLL,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [4:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic CMD_STB,
  input wire logic [7:0] CMD_CODE,
  input wire logic TX_START,
  input wire logic TX_DONE,
  input wire logic SLOT_START,
  input wire logic RX_DONE,
  input wire logic [2:0] RX_ERR,
  input wire rtc_pkg::rtc_lvl_t LVL_IN,
  output logic RX_DECODER_RST,
  output logic TX_ENABLE,
  output logic IRQ
);
  // ------------------------------------------------------------
  // Link domain: bit counting and collision capture
  // ------------------------------------------------------------
  logic [1:0] lrst_sync;
  logic [1:0] lce_sync;
  logic [POS_W-1:0] bit_cnt;
  logic [POS_W-1:0] col_pos;
  logic sof_tgl;
  logic col_tgl;

  // Reset and enable brought over into the link clock
  always_ff @(posedge LNK_CLK) begin
    lrst_sync <= {lrst_sync[0], SYS_RST};
    lce_sync <= {lce_sync[0], CLK_EN};
  end

  // Count restarts at the start bit, first data bit reads as zero
  always_ff @(posedge LNK_CLK) begin
    if (lrst_sync[1]) begin
      bit_cnt <= '0;
      col_pos <= '0;
      sof_tgl <= 1'b0;
      col_tgl <= 1'b0;
    end else if (lce_sync[1]) begin
      if (LNK_SOF) begin
        bit_cnt <= '0; // see RULE3
        sof_tgl <= ~sof_tgl;
      end else if (LNK_BIT) begin
        bit_cnt <= bit_cnt + 1'b1; // see RULE3
        if (LNK_COLL) begin
          col_pos <= bit_cnt;
          col_tgl <= ~col_tgl;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Crossings into the system clock
  // ------------------------------------------------------------
  logic [2:0] sof_s;
  logic [2:0] col_s;
  rtc_pkg::rtc_lvl_t lvl_s1;
  rtc_pkg::rtc_lvl_t lvl_s2;
  logic sof_ev;
  logic col_ev;

  // Toggles pass two flops; third flop only feeds edge detection
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      sof_s <= 3'h0;
      col_s <= 3'h0;
    end else if (CLK_EN) begin
      sof_s <= {sof_s[1:0], sof_tgl};
      col_s <= {col_s[1:0], col_tgl};
    end
  end

  // Analog level codes are asynchronous to this clock
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      lvl_s1 <= '0;
      lvl_s2 <= '0;
    end else if (CLK_EN) begin
      lvl_s1 <= LVL_IN;
      lvl_s2 <= lvl_s1;
    end
  end

  assign sof_ev = sof_s[2] ^ sof_s[1];
  assign col_ev = col_s[2] ^ col_s[1];

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [1:0] proto_class(input logic [7:0] p);
    if (p[4:3] == 2'b00) begin
      proto_class = 2'd0;
    end else if (p[4:2] == 3'b010) begin
      proto_class = 2'd1;
    end else if (p[4:2] == 3'b011) begin
      proto_class = 2'd2;
    end else begin
      proto_class = 2'd3;
    end
  endfunction : proto_class

  function automatic logic [15:0] presets(input logic [7:0] p);
    case (proto_class(p))
      2'd0: presets = {rtc_pkg::PRE_VIC_RXW, rtc_pkg::PRE_VIC_NRS};
      2'd1: presets = {rtc_pkg::PRE_A_RXW, rtc_pkg::PRE_A_NRS};
      2'd2: presets = {rtc_pkg::PRE_B_RXW, rtc_pkg::PRE_B_NRS};
      default: presets = {rtc_pkg::PRE_OTH_RXW, rtc_pkg::PRE_OTH_NRS};
    endcase
  endfunction : presets

  function automatic logic [2:0] peak(input logic [2:0] a, input logic [2:0] b);
    peak = (a > b) ? a : b;
  endfunction : peak

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  logic [7:0] csc_reg;
  logic [7:0] proto_reg;
  logic [7:0] nrs_reg;
  logic [7:0] rxw_reg;
  logic [5:0] mask_reg;
  logic wr_proto;
  logic [15:0] pre_val;

  assign wr_proto = REG_WR && (REG_ADDR == rtc_pkg::ADR_PROTO);
  assign pre_val = presets(REG_WDATA);

  // Protocol write reloads both timer presets; order matters to host
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      csc_reg <= rtc_pkg::CSC_RST;
      proto_reg <= rtc_pkg::PROTO_RST;
      rxw_reg <= rtc_pkg::PRE_VIC_RXW;
      nrs_reg <= rtc_pkg::PRE_VIC_NRS;
      mask_reg <= rtc_pkg::MASK_RST;
    end else if (CLK_EN && REG_WR) begin
      case (REG_ADDR)
        rtc_pkg::ADR_CSC: csc_reg <= REG_WDATA;
        rtc_pkg::ADR_PROTO: begin
          proto_reg <= REG_WDATA;
          rxw_reg <= pre_val[15:8]; // see RULE5 see RULE17
          nrs_reg <= pre_val[7:0]; // see RULE7 see RULE17
        end
        rtc_pkg::ADR_NORESP: nrs_reg <= REG_WDATA;
        rtc_pkg::ADR_RXWAIT: rxw_reg <= REG_WDATA;
        rtc_pkg::ADR_COLHI: mask_reg <= REG_WDATA[5:0];
        default: ;
      endcase
    end
  end

  assign TX_ENABLE = csc_reg[rtc_pkg::CSC_TX_BIT];

  // ------------------------------------------------------------
  // Decoder blanking timer
  // ------------------------------------------------------------
  logic [15:0] rxw_pre;
  logic [7:0] rxw_units;

  // Units of 9.44 us rounded up to whole core clocks (9.5 us at 10 MHz), from a fixed prescale of the core clock
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      rxw_pre <= '0;
      rxw_units <= '0;
    end else if (CLK_EN) begin
      if (TX_DONE) begin
        rxw_units <= rxw_reg; // see RULE4
        rxw_pre <= 16'(rtc_pkg::RXW_TICKS - 1); // see RULE21
      end else if (rxw_units != 8'h00) begin
        if (rxw_pre == 16'h0000) begin
          rxw_pre <= 16'(rtc_pkg::RXW_TICKS - 1);
          rxw_units <= rxw_units - 8'h01;
        end else begin
          rxw_pre <= rxw_pre - 16'h0001;
        end
      end
    end
  end

  assign RX_DECODER_RST = (rxw_units != 8'h00); // see RULE4

  // ------------------------------------------------------------
  // No-response timer
  // ------------------------------------------------------------
  rtc_pkg::rtc_nr_t nr_state;
  logic [15:0] nr_pre;
  logic [7:0] nr_units;
  logic nr_expire;

  assign nr_expire = (nr_state == rtc_pkg::NR_RUN) && !sof_ev &&
                     (nr_units == 8'h01) && (nr_pre == 16'h0000);

  // Slot start arms it, tag start of frame disarms it
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      nr_state <= rtc_pkg::NR_IDLE;
      nr_pre <= '0;
      nr_units <= '0;
    end else if (CLK_EN) begin
      case (nr_state)
        rtc_pkg::NR_IDLE: begin
          if (SLOT_START && nrs_reg != 8'h00) begin
            nr_state <= rtc_pkg::NR_RUN; // see RULE6
            nr_units <= nrs_reg;
            nr_pre <= 16'(rtc_pkg::NRS_TICKS - 1); // see RULE21
          end
        end
        rtc_pkg::NR_RUN: begin
          if (sof_ev || nr_expire) begin
            nr_state <= rtc_pkg::NR_IDLE;
          end else if (nr_pre == 16'h0000) begin
            nr_pre <= 16'(rtc_pkg::NRS_TICKS - 1);
            nr_units <= nr_units - 8'h01;
          end else begin
            nr_pre <= nr_pre - 16'h0001;
          end
        end
        default: nr_state <= rtc_pkg::NR_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Collision position
  // ------------------------------------------------------------
  logic [7:0] col_lo_reg;
  logic [1:0] col_hi_reg;

  // Link value is held until the next collision, so safe to sample here
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      col_lo_reg <= '0;
      col_hi_reg <= '0;
    end else if (CLK_EN && col_ev && proto_class(proto_reg) == 2'd1) begin
      col_lo_reg <= col_pos[7:0]; // see RULE2
      col_hi_reg <= col_pos[9:8]; // see RULE2
    end
  end

  // ------------------------------------------------------------
  // Interrupt flags, cleared by reading
  // ------------------------------------------------------------
  logic [7:0] flags_reg;
  logic [7:0] flag_set;
  logic rd_flags;

  assign rd_flags = REG_RD && (REG_ADDR == rtc_pkg::ADR_FLAGS);

  always_comb begin
    flag_set = 8'h00;
    flag_set[rtc_pkg::FLG_TX] = TX_DONE;
    flag_set[rtc_pkg::FLG_RX] = RX_DONE; // see RULE18
    flag_set[rtc_pkg::FLG_ERR +: 3] = RX_ERR; // see RULE19
    flag_set[rtc_pkg::FLG_COL] = col_ev; // see RULE1
    flag_set[rtc_pkg::FLG_NRS] = nr_expire; // see RULE6
  end

  // An event in the clearing cycle survives the clear
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      flags_reg <= '0;
    end else if (CLK_EN) begin
      flags_reg <= (rd_flags ? 8'h00 : flags_reg) | flag_set; // see RULE19
    end
  end

  assign IRQ = |(flags_reg & {mask_reg, 2'b11}); // see RULE1 see RULE18

  // ------------------------------------------------------------
  // Signal strength
  // ------------------------------------------------------------
  logic [2:0] main_pk;
  logic [2:0] aux_pk;
  logic [7:0] ssl_reg;
  logic [7:0] ssl_int;
  logic [7:0] ssl_ext;
  logic ssl_store;
  logic use_ext;

  // Peaks track the highest code since the last transmission
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      main_pk <= '0;
      aux_pk <= '0;
    end else if (CLK_EN) begin
      if (TX_START) begin
        main_pk <= '0; // see RULE9
        aux_pk <= '0;
      end else begin
        main_pk <= peak(main_pk, lvl_s2.main); // see RULE8
        aux_pk <= peak(aux_pk, lvl_s2.aux);
      end
    end
  end

  assign ssl_int = {2'b01, aux_pk, main_pk}; // see RULE10
  assign ssl_ext = {2'b01, 3'b000, lvl_s2.ext};
  assign use_ext = (CMD_STB && CMD_CODE == rtc_pkg::CMD_EXT_SSL) ||
                   csc_reg[rtc_pkg::CSC_EXT_BIT]; // see RULE11
  assign ssl_store = RX_DONE || (CMD_STB &&
                     (CMD_CODE == rtc_pkg::CMD_INT_SSL ||
                      CMD_CODE == rtc_pkg::CMD_EXT_SSL)); // see RULE12

  // A store in the read cycle wins so no result is lost
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ssl_reg <= rtc_pkg::SSL_RST;
    end else if (CLK_EN) begin
      if (ssl_store) begin
        ssl_reg <= use_ext ? ssl_ext : ssl_int; // see RULE12
      end else if (TX_START) begin
        ssl_reg <= rtc_pkg::SSL_RST; // see RULE9
      end else if (REG_RD && REG_ADDR == rtc_pkg::ADR_SSL) begin
        ssl_reg <= rtc_pkg::SSL_RST; // see RULE15
      end
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  // Unmapped offsets read as zero
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      REG_RDATA <= '0;
    end else if (CLK_EN && REG_RD) begin
      case (REG_ADDR)
        rtc_pkg::ADR_CSC: REG_RDATA <= csc_reg;
        rtc_pkg::ADR_PROTO: REG_RDATA <= proto_reg;
        rtc_pkg::ADR_NORESP: REG_RDATA <= nrs_reg;
        rtc_pkg::ADR_RXWAIT: REG_RDATA <= rxw_reg;
        rtc_pkg::ADR_FLAGS: REG_RDATA <= flags_reg;
        rtc_pkg::ADR_COLHI: REG_RDATA <= {col_hi_reg, mask_reg}; // see RULE2
        rtc_pkg::ADR_COLLO: REG_RDATA <= col_lo_reg;
        rtc_pkg::ADR_SSL: REG_RDATA <= ssl_reg;
        default: REG_RDATA <= 8'h00;
      endcase
    end
  end
endmodule : rtc_core

//--- rtc_core_asserts.sv
/*
  Checker for rtc_core: timing and register relations at its ports.
  Assumes one CLK_SYS domain with synchronous active-high SYS_RST.
*/
`timescale 1ns/1ns
module rtc_core_chk (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [4:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  input wire logic CMD_STB,
  input wire logic [7:0] CMD_CODE,
  input wire logic TX_START,
  input wire logic TX_DONE,
  input wire logic RX_DONE,
  input wire rtc_pkg::rtc_lvl_t LVL_IN,
  input wire logic RX_DECODER_RST,
  input wire logic TX_ENABLE,
  input wire logic IRQ
);
  localparam int BLK_TICKS = rtc_pkg::RXW_TICKS;
  logic [15:0] blk_cnt_reg;
  logic ext_pend_reg;
  logic rd_ssl, quiet, wd_tx;
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (SYS_RST);
  // Strength read, and a cycle with no store or clear source
  assign rd_ssl = REG_RD && CLK_EN && REG_ADDR == rtc_pkg::ADR_SSL;
  assign quiet = !CMD_STB && !RX_DONE && !TX_START;
  assign wd_tx = REG_WDATA[rtc_pkg::CSC_TX_BIT];
  // Blanking run length; a new end of transmit restarts it
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST || TX_DONE) begin
      blk_cnt_reg <= 16'h0000;
    end else if (RX_DECODER_RST && CLK_EN) begin
      blk_cnt_reg <= blk_cnt_reg + 16'h0001;
    end
  end
  // External store not yet read; any other store or clear drops it
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ext_pend_reg <= 1'b0;
    end else if (CLK_EN && (CMD_STB || rd_ssl || TX_START || RX_DONE)) begin
      ext_pend_reg <= CMD_STB && CMD_CODE == rtc_pkg::CMD_EXT_SSL && !rd_ssl
        && !TX_START && !RX_DONE;
    end
  end
  sequence s_tx_clear;
    TX_START && CLK_EN && !CMD_STB && !RX_DONE;
  endsequence
  sequence s_rd_clean;
    rd_ssl && quiet;
  endsequence
  a_blank_cause: assert property ($rose(RX_DECODER_RST) |-> $past(TX_DONE))
    else $error("blanking began without end of transmit");
  a_blank_units: assert property ($fell(RX_DECODER_RST) |-> blk_cnt_reg != 16'h0000
    && int'(blk_cnt_reg) % BLK_TICKS == 0) else $error("blanking not whole units");
  a_rx_irq: assert property (RX_DONE && CLK_EN |-> ##[1:2] IRQ)
    else $error("no request after receive end");
  a_tx_follow: assert property (REG_WR && CLK_EN && REG_ADDR == rtc_pkg::ADR_CSC
    |=> TX_ENABLE == $past(wd_tx)) else $error("transmit enable wrong");
  a_ssl_range: assert property (rd_ssl |=> REG_RDATA[7:6] == 2'h1)
    else $error("strength value out of range");
  a_rd_clear: assert property (s_rd_clean ##1 s_rd_clean |=> REG_RDATA == rtc_pkg::SSL_RST)
    else $error("strength not cleared by read");
  a_tx_clear: assert property (s_tx_clear ##1 s_rd_clean |=> REG_RDATA == rtc_pkg::SSL_RST)
    else $error("strength not cleared by transmit");
  a_ext_store: assert property (rd_ssl && ext_pend_reg && quiet
    |=> REG_RDATA == {2'h1, 3'h0, LVL_IN.ext}) else $error("external level wrong");
endmodule : rtc_core_chk
bind rtc_core rtc_core_chk chk_u (.CLK_SYS, .SYS_RST, .CLK_EN, .REG_WR, .REG_RD,
  .REG_ADDR, .REG_WDATA, .REG_RDATA, .CMD_STB, .CMD_CODE, .TX_START, .TX_DONE,
  .RX_DONE, .LVL_IN, .RX_DECODER_RST, .TX_ENABLE, .IRQ);

//--- rtc_lnk_model.sv
/*
  Link-side model: start bit, decoded bits and one collision mark.
  Assumes the bench calls send_frame; its clock idles between frames.
*/
`timescale 1ns/1ns
module rtc_lnk_model (
  output logic lnk_clk,
  output logic lnk_sof,
  output logic lnk_bit,
  output logic lnk_coll
);
  logic run = 1'b1;
  // 15 ns clock, running through reset and within frames only
  always begin
    lnk_clk = 1'b0;
    #8;
    lnk_clk = run;
    #7;
  end
  // Runs long enough for the link side to leave reset
  initial begin
    lnk_sof = 1'b0;
    lnk_bit = 1'b0;
    lnk_coll = 1'b0;
    #2000 run = 1'b0;
  end
  // Bit pulses are two link cycles apart, so collisions stay well spaced
  task automatic send_frame(input int nbits, input int coll_at);
    run = 1'b1;
    repeat (3) @(posedge lnk_clk);
    lnk_sof <= 1'b1;
    for (int i = 0; i < nbits; i++) begin
      @(posedge lnk_clk);
      lnk_sof <= 1'b0;
      lnk_bit <= 1'b1;
      lnk_coll <= (i == coll_at);
      @(posedge lnk_clk);
      lnk_bit <= 1'b0;
      lnk_coll <= 1'b0;
    end
    repeat (3) @(posedge lnk_clk);
    lnk_sof <= 1'b0;
    run = 1'b0;
  endtask : send_frame
endmodule : rtc_lnk_model

//--- rtc_pkg.sv
/*
  Constants and carrier types for the receive timers, collision and
  signal strength block. Assumes a 10 MHz system clock.
*/
package rtc_pkg;
  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [4:0] ADR_CSC = 5'h00;
  localparam logic [4:0] ADR_PROTO = 5'h01;
  localparam logic [4:0] ADR_NORESP = 5'h07;
  localparam logic [4:0] ADR_RXWAIT = 5'h08;
  localparam logic [4:0] ADR_FLAGS = 5'h0C;
  localparam logic [4:0] ADR_COLHI = 5'h0D;
  localparam logic [4:0] ADR_COLLO = 5'h0E;
  localparam logic [4:0] ADR_SSL = 5'h0F;
  // ------------------------------------------------------------
  // Reset values and field positions
  // ------------------------------------------------------------
  localparam logic [7:0] CSC_RST = 8'h01;
  localparam logic [7:0] PROTO_RST = 8'h02;
  localparam logic [5:0] MASK_RST = 6'h3F;
  localparam logic [7:0] SSL_RST = 8'h40;
  localparam int CSC_EXT_BIT = 1;
  localparam int CSC_TX_BIT = 5;
  localparam int FLG_TX = 7;
  localparam int FLG_RX = 6;
  localparam int FLG_ERR = 2;
  localparam int FLG_COL = 1;
  localparam int FLG_NRS = 0;
  localparam logic [7:0] CMD_INT_SSL = 8'h18;
  localparam logic [7:0] CMD_EXT_SSL = 8'h19;
  // ------------------------------------------------------------
  // Protocol presets (blanking units, no-response units)
  // ------------------------------------------------------------
  localparam logic [7:0] PRE_VIC_RXW = 8'h1F;
  localparam logic [7:0] PRE_VIC_NRS = 8'h21;
  localparam logic [7:0] PRE_A_RXW = 8'h07;
  localparam logic [7:0] PRE_A_NRS = 8'h0E;
  localparam logic [7:0] PRE_B_RXW = 8'h07;
  localparam logic [7:0] PRE_B_NRS = 8'h0E;
  localparam logic [7:0] PRE_OTH_RXW = 8'h1F;
  localparam logic [7:0] PRE_OTH_NRS = 8'h21;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 10;
  localparam int RXW_UNIT_NS = 9440;
  localparam int NRS_UNIT_NS = 37760;
  localparam int RXW_TICKS = (RXW_UNIT_NS * CLK_MHZ + 999) / 1000;
  localparam int NRS_TICKS = (NRS_UNIT_NS * CLK_MHZ + 999) / 1000;
  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [2:0] ext;
    logic [2:0] aux;
    logic [2:0] main;
  } rtc_lvl_t;
  typedef enum logic [1:0] {
    NR_IDLE = 2'b01,
    NR_RUN = 2'b10
  } rtc_nr_t;
endpackage : rtc_pkg

//--- tb.sv
/*
  Self-checking bench for rtc_core: register traffic, frame events and
  link frames. Assumes the checker binds itself to the core.
*/
`timescale 1ns/1ns
module tb;
  localparam int LIMIT = 10000;
  localparam logic [15:0] RV [9] = '{16'h0001, 16'h0102, 16'h0721, 16'h081F,
    16'h0C00, 16'h0D3F, 16'h0E00, 16'h0F40, 16'h0200};
  localparam logic [23:0] PT [4] = '{24'h001F21, 24'h08070E, 24'h0C070E, 24'h101F21};
  logic clk = 1'b0, rst = 1'b1, clk_en = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [7:0] wdata = 8'h00, cmd = 8'h00, ev = 8'h00, rdata;
  rtc_pkg::rtc_lvl_t lvl = 9'h000;
  logic lnk_clk, sof, bit_v, coll, blank, tx_en, irq;
  int bad_count = 0, check_count = 0, cyc = 0, blank_n = 0;
  rtc_lnk_model lnk_u (.lnk_clk(lnk_clk), .lnk_sof(sof), .lnk_bit(bit_v), .lnk_coll(coll));
  rtc_core dut_u (.CLK_SYS(clk), .SYS_RST(rst), .CLK_EN(clk_en), .LNK_CLK(lnk_clk),
    .LNK_SOF(sof), .LNK_BIT(bit_v), .LNK_COLL(coll), .REG_WR(wr), .REG_RD(rd),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .CMD_STB(ev[4]),
    .CMD_CODE(cmd), .TX_START(ev[0]), .TX_DONE(ev[1]), .SLOT_START(ev[2]),
    .RX_DONE(ev[3]), .RX_ERR(ev[7:5]), .LVL_IN(lvl), .RX_DECODER_RST(blank),
    .TX_ENABLE(tx_en), .IRQ(irq));
  always #50 clk = ~clk;
  // Cycle ceiling
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      bad_count++;
      finish_test();
    end
  end
  // Blanking length, counted at the falling edge where the level has settled
  always @(negedge clk) begin
    if (blank) blank_n++;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg
  // Data is registered, so it is judged at the falling edge
  task automatic rd_reg(input logic [4:0] a, input logic [7:0] exp, input string msg);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp, msg);
    @(posedge clk);
  endtask : rd_reg
  task automatic pulse(input logic [7:0] m);
    ev <= m;
    @(posedge clk);
    ev <= 8'h00;
    @(posedge clk);
  endtask : pulse
  task automatic irq_is(input logic v, input string msg);
    @(negedge clk);
    chk({7'h00, irq}, {7'h00, v}, msg);
    @(posedge clk);
  endtask : irq_is
  // Command, then the host's settling wait of 50 us
  task automatic measure(input logic [7:0] c);
    cmd <= c;
    pulse(8'h10);
    repeat (500) @(posedge clk);
  endtask : measure
  task automatic t_reset();
    for (int i = 0; i < 9; i++) rd_reg(RV[i][12:8], RV[i][7:0], "reset value");
    wr_reg(rtc_pkg::ADR_FLAGS, 8'hFF);
    rd_reg(rtc_pkg::ADR_FLAGS, 8'h00, "read-only flags");
    $display("t_reset done");
  endtask : t_reset
  task automatic t_proto();
    for (int i = 0; i < 4; i++) begin
      wr_reg(rtc_pkg::ADR_PROTO, PT[i][23:16]);
      rd_reg(rtc_pkg::ADR_RXWAIT, PT[i][15:8], "blank preset");
      rd_reg(rtc_pkg::ADR_NORESP, PT[i][7:0], "timeout preset");
    end
    wr_reg(rtc_pkg::ADR_PROTO, 8'h08);
    wr_reg(rtc_pkg::ADR_RXWAIT, 8'h02);
    clk_en <= 1'b0;
    wr_reg(rtc_pkg::ADR_RXWAIT, 8'h55);
    clk_en <= 1'b1;
    rd_reg(rtc_pkg::ADR_RXWAIT, 8'h02, "frozen write");
    wr_reg(rtc_pkg::ADR_PROTO, 8'h08);
    rd_reg(rtc_pkg::ADR_RXWAIT, 8'h07, "reload");
    wr_reg(rtc_pkg::ADR_RXWAIT, 8'h02);
    wr_reg(rtc_pkg::ADR_NORESP, 8'h01);
    $display("t_proto done");
  endtask : t_proto
  task automatic t_timers();
    int n0;
    n0 = blank_n;
    pulse(8'h02);
    repeat (200) @(posedge clk);
    chk(8'(blank_n - n0), 8'hBE, "blank cycles");
    rd_reg(rtc_pkg::ADR_FLAGS, 8'h80, "tx done flag");
    pulse(8'h04);
    repeat (376) @(posedge clk);
    irq_is(1'b0, "early timeout");
    repeat (3) @(posedge clk);
    irq_is(1'b1, "timeout request");
    rd_reg(rtc_pkg::ADR_FLAGS, 8'h01, "timeout flag");
    pulse(8'h04);
    lnk_u.send_frame(0, 99);
    repeat (500) @(posedge clk);
    rd_reg(rtc_pkg::ADR_FLAGS, 8'h00, "answered slot");
    $display("t_timers done");
  endtask : t_timers
  task automatic t_coll();
    lnk_u.send_frame(17, 16);
    repeat (10) @(posedge clk);
    rd_reg(rtc_pkg::ADR_FLAGS, 8'h02, "collision flag");
    rd_reg(rtc_pkg::ADR_COLLO, 8'h10, "first id bit");
    lnk_u.send_frame(301, 300);
    repeat (10) @(posedge clk);
    rd_reg(rtc_pkg::ADR_COLHI, 8'h7F, "position top");
    rd_reg(rtc_pkg::ADR_COLLO, 8'h2C, "position low");
    wr_reg(rtc_pkg::ADR_PROTO, 8'h0C);
    lnk_u.send_frame(4, 2);
    repeat (10) @(posedge clk);
    rd_reg(rtc_pkg::ADR_FLAGS, 8'h02, "type B flag");
    rd_reg(rtc_pkg::ADR_COLLO, 8'h2C, "type B kept");
    $display("t_coll done");
  endtask : t_coll
  task automatic t_ssl();
    wr_reg(rtc_pkg::ADR_CSC, 8'h21);
    irq_is(1'b0, "quiet request");
    chk({7'h00, tx_en}, 8'h01, "transmitter on");
    lvl <= 9'h19E;
    repeat (10) @(posedge clk);
    lvl <= 9'h19A;
    measure(8'h18);
    rd <= 1'b1;
    addr <= rtc_pkg::ADR_SSL;
    @(posedge clk);
    @(negedge clk);
    chk(rdata, 8'h5E, "internal peaks");
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, 8'h40, "read clears");
    @(posedge clk);
    measure(8'h19);
    rd_reg(rtc_pkg::ADR_SSL, 8'h46, "external cmd");
    wr_reg(rtc_pkg::ADR_CSC, 8'h03);
    chk({7'h00, tx_en}, 8'h00, "transmitter off");
    measure(8'h18);
    rd_reg(rtc_pkg::ADR_SSL, 8'h46, "external selected");
    wr_reg(rtc_pkg::ADR_CSC, 8'h21);
    measure(8'h18);
    ev <= 8'h01;
    @(posedge clk);
    ev <= 8'h00;
    rd_reg(rtc_pkg::ADR_SSL, 8'h40, "transmit clears");
    cmd <= 8'h17;
    pulse(8'h10);
    rd_reg(rtc_pkg::ADR_SSL, 8'h40, "unknown command");
    pulse(8'hE8);
    irq_is(1'b1, "receive request");
    rd_reg(rtc_pkg::ADR_FLAGS, 8'h5C, "receive causes");
    rd_reg(rtc_pkg::ADR_SSL, 8'h5A, "receive store");
    $display("t_ssl done");
  endtask : t_ssl
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_proto();
    t_timers();
    t_coll();
    t_ssl();
    finish_test();
  end
endmodule : tb
